/* File: slts_cfg.svh */
// slts_cfg.svh - register indices, field positions, reset values and
// character codes of the serial link test and status register bank.
// assumes: byte address of a register is four times its index.
`ifndef SLTS_CFG_SVH
`define SLTS_CFG_SVH

// register indices; byte address is index * 4
`define SLTS_IDX_TEST 10'h205
`define SLTS_IDX_DEVNUM 10'h206
`define SLTS_IDX_COMMA 10'h207
`define SLTS_IDX_COND 10'h208
`define SLTS_IDX_CTRL 10'h210

// reset values
`define SLTS_RST_TEST 5'h00
`define SLTS_RST_DEVNUM 7'h00
`define SLTS_RST_COMMA 2'h0

// status and control bit positions
`define SLTS_BIT_UP 6
`define SLTS_BIT_SYNC 5
`define SLTS_BIT_REALIGN 4
`define SLTS_BIT_ALIGN 3
`define SLTS_BIT_LOCK 2
`define SLTS_BIT_EN 0
`define SLTS_BIT_8B10B 1

// 8b/10b control and data characters
`define SLTS_K28_0 8'h1C
`define SLTS_K28_1 8'h3C
`define SLTS_K28_3 8'h7C
`define SLTS_K28_4 8'h9C
`define SLTS_K28_5 8'hBC
`define SLTS_K28_7 8'hFC
`define SLTS_D21_5 8'hB5
`define SLTS_CLK_WORD 16'h00FF

`endif

/* File: slts_pkg.sv */
// slts_pkg.sv - types of the serial link test and status block.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none

package slts_pkg;

   // test selector codes
   typedef enum logic [4:0] {
      pat_off = 5'h00,
      pat_prbs7 = 5'h01,
      pat_prbs15 = 5'h02,
      pat_prbs23 = 5'h03,
      pat_ramp = 5'h04,
      pat_transport = 5'h05,
      pat_d215 = 5'h06,
      pat_k285 = 5'h07,
      pat_ila = 5'h08,
      pat_rpat = 5'h09,
      pat_low = 5'h0A,
      pat_high = 5'h0B,
      pat_prbs9 = 5'h0D,
      pat_prbs31 = 5'h0E,
      pat_clock = 5'h0F,
      pat_k287 = 5'h10
   } slts_pattern_type;

endpackage: slts_pkg

`default_nettype wire

/* File: slts_skid.sv */
// slts_skid.sv - two-entry buffer with valid and ready on both sides.
// assumes: one clock; all outputs straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none

module slts_skid #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // filling side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // draining side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   logic spare_valid_q;
   logic [W-1:0] spare_data_q;
   logic push;

   assign push = in_valid & in_ready;

   ////////////////////////////////////////////////////////////////////
   // occupancy; ready is its own flop so the source sees no comb path
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         spare_valid_q <= 1'b0;
         in_ready <= 1'b1;
      end else if (!out_valid || out_ready) begin
         if (spare_valid_q) begin
            out_valid <= 1'b1;
            spare_valid_q <= 1'b0;
            in_ready <= 1'b1;
         end else begin
            out_valid <= push;
         end
      end else if (push) begin
         spare_valid_q <= 1'b1;
         in_ready <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_data <= '0;
         spare_data_q <= '0;
      end else begin
         if (!out_valid || out_ready) begin
            out_data <= spare_valid_q ? spare_data_q : in_data;
         end
         if (push) begin
            spare_data_q <= in_data;
         end
      end
   end

endmodule: slts_skid

`default_nettype wire

/* File: slts_lane_gen.sv */
// slts_lane_gen.sv - one lane's word source: samples or a test pattern.
// assumes: advance pulses once per word taken; outputs are combinational.
`timescale 1ns/1ps
`default_nettype none
`include "slts_cfg.svh"

module slts_lane_gen #(
   parameter int LANE = 0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic advance,
   input wire logic [4:0] sel,
   input wire logic mode_8b10b,
   input wire logic [7:0] ila_device_number,
   input wire logic [7:0] comma,
   // samples
   input wire logic [15:0] sample,
   input wire logic eof_ok,
   // word out
   output logic [15:0] word,
   output logic [1:0] k,
   output logic raw
);

   logic [30:0] lfsr_q;
   logic [7:0] cnt_q;

   // sixteen serial steps; newest bit lands in bit 0
   function automatic logic [30:0] prbs_next(input logic [30:0] s, input logic [4:0] t);
      logic [30:0] r;
      logic fb;
      r = s;
      fb = 1'b0;
      for (int i = 0; i < 16; i++) begin
         case (t)
            slts_pkg::pat_prbs7: fb = r[6] ^ r[5];
            slts_pkg::pat_prbs9: fb = r[8] ^ r[4];
            slts_pkg::pat_prbs15: fb = r[14] ^ r[13];
            slts_pkg::pat_prbs23: fb = r[22] ^ r[17];
            default: fb = r[30] ^ r[27];
         endcase
         r = {r[29:0], fb};
      end
      return r;
   endfunction: prbs_next

   ////////////////////////////////////////////////////////////////////
   // per-lane seed, own register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lfsr_q <= 31'(LANE + 1);
      end else if (advance) begin
         lfsr_q <= prbs_next(lfsr_q, sel);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else if (advance) begin
         cnt_q <= cnt_q + ((sel == slts_pkg::pat_ramp) ? 8'h02 : 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      word = 16'h0000;
      k = 2'b00;
      raw = 1'b0;
      case (sel)
         slts_pkg::pat_off: begin
            word = sample;
            if (mode_8b10b && eof_ok) begin
               word[7:0] = comma;
               k = 2'b01;
            end
         end
         slts_pkg::pat_prbs7, slts_pkg::pat_prbs9, slts_pkg::pat_prbs15,
         slts_pkg::pat_prbs23, slts_pkg::pat_prbs31: begin
            word = lfsr_q[15:0];
            raw = 1'b1;
         end
         slts_pkg::pat_ramp: word = {cnt_q + 8'h01, cnt_q};
         slts_pkg::pat_transport: word = {8'(LANE), cnt_q};
         slts_pkg::pat_d215: word = {`SLTS_D21_5, `SLTS_D21_5};
         slts_pkg::pat_k285: if (mode_8b10b) begin
            word = {`SLTS_K28_5, `SLTS_K28_5};
            k = 2'b11;
         end
         slts_pkg::pat_k287: if (mode_8b10b) begin
            word = {`SLTS_K28_7, `SLTS_K28_7};
            k = 2'b11;
         end
         slts_pkg::pat_rpat: if (mode_8b10b) begin
            word = {cnt_q ^ 8'hBE, cnt_q ^ 8'hD7};
         end
         slts_pkg::pat_ila: if (mode_8b10b) begin
            word = {cnt_q, cnt_q};
            if (cnt_q[1:0] == 2'h0) begin
               word[7:0] = `SLTS_K28_0;
               k = 2'b01;
            end else if (cnt_q[1:0] == 2'h3) begin
               word[15:8] = `SLTS_K28_3;
               k = 2'b10;
            end else if (cnt_q[3:0] == 4'h5) begin
               word = {ila_device_number, `SLTS_K28_4};
               k = 2'b01;
            end
         end
         slts_pkg::pat_low: raw = 1'b1;
         slts_pkg::pat_high: begin
            word = 16'hFFFF;
            raw = 1'b1;
         end
         slts_pkg::pat_clock: begin
            word = `SLTS_CLK_WORD;
            raw = 1'b1;
         end
         default: word = 16'h0000;
      endcase
   end

endmodule: slts_lane_gen

`default_nettype wire

/* File: slts_regs.sv */
// slts_regs.sv - serial link test and status registers with the lane
// word source: wishbone slave, test pattern selection, link status.
// assumes: one clock; inputs synchronous; lane consumer obeys ready.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "slts_cfg.svh"

module slts_regs #(
   parameter int LPL = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // link status inputs
   input wire logic link_up,
   input wire logic sync_n,
   input wire logic pll_locked,
   input wire logic sysref_event,
   input wire logic realign_event,
   // control outputs
   output logic link_transmit_enable,
   output logic link_mode_8b10b,
   // sample stream in
   input wire logic [2*LPL*16-1:0] sample_data,
   input wire logic [2*LPL-1:0] sample_eof_ok,
   input wire logic sample_valid,
   output logic sample_ready,
   // lane stream out
   output logic [2*LPL*16-1:0] lane_data,
   output logic [2*LPL*2-1:0] lane_k,
   output logic [2*LPL-1:0] lane_raw,
   output logic lane_valid,
   input wire logic lane_ready
);

   localparam int LANES = 2 * LPL;
   localparam int BW = LANES * 19;

   logic ack_q;
   logic [31:0] dat_q;
   logic [4:0] test_q;
   logic [6:0] devnum_q;
   logic [1:0] comma_sel_q;
   logic en_q;
   logic mode_q;
   logic realign_q;
   logic align_q;
   logic sysref_seen_q;
   logic req;
   logic rd;
   logic wr;
   logic [7:0] comma_w;
   logic in_valid;
   logic adv;
   logic [LANES*16-1:0] word_w;
   logic [LANES*2-1:0] k_w;
   logic [LANES-1:0] raw_w;
   logic [BW-1:0] buf_out;

   function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
      return a[11:2] == idx;
   endfunction: hit

   ////////////////////////////////////////////////////////////////////
   // bus decode; one wait state, every access answered
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign rd = req & ~wb_we_i;
   // write lands on the edge where the master samples ack
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign link_transmit_enable = en_q;
   assign link_mode_8b10b = mode_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // setup registers; upper lanes ignored, only lane 0 holds data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         test_q <= `SLTS_RST_TEST;
         devnum_q <= `SLTS_RST_DEVNUM;
         comma_sel_q <= `SLTS_RST_COMMA;
         en_q <= 1'b0;
         mode_q <= 1'b0;
      end else if (wr) begin
         if (hit(wb_adr_i, `SLTS_IDX_TEST)) begin
            test_q <= wb_dat_i[4:0];
         end
         if (hit(wb_adr_i, `SLTS_IDX_DEVNUM)) begin
            devnum_q <= wb_dat_i[7:1];
         end
         if (hit(wb_adr_i, `SLTS_IDX_COMMA)) begin
            comma_sel_q <= wb_dat_i[1:0];
         end
         if (hit(wb_adr_i, `SLTS_IDX_CTRL)) begin
            en_q <= wb_dat_i[`SLTS_BIT_EN];
            mode_q <= wb_dat_i[`SLTS_BIT_8B10B];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sticky status; a set in the clearing cycle wins
   // realign sticky, write one clears
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         realign_q <= 1'b0;
      end else if (realign_event) begin
         realign_q <= 1'b1;
      end else if (wr && hit(wb_adr_i, `SLTS_IDX_COND) && wb_dat_i[`SLTS_BIT_REALIGN]) begin
         realign_q <= 1'b0;
      end
   end

   // first sysref after enable only; disabling rearms it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sysref_seen_q <= 1'b0;
      end else if (!en_q) begin
         sysref_seen_q <= 1'b0;
      end else if (sysref_event) begin
         sysref_seen_q <= 1'b1;
      end
   end

   // phase set flag, write one clears
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         align_q <= 1'b0;
      end else if (en_q && sysref_event && !sysref_seen_q) begin
         align_q <= 1'b1;
      end else if (wr && hit(wb_adr_i, `SLTS_IDX_COND) && wb_dat_i[`SLTS_BIT_ALIGN]) begin
         align_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dat_q <= 32'h00000000;
      end else if (rd) begin
         dat_q <= 32'h00000000;
         if (hit(wb_adr_i, `SLTS_IDX_TEST)) begin
            dat_q[4:0] <= test_q;
         end
         if (hit(wb_adr_i, `SLTS_IDX_DEVNUM)) begin
            dat_q[7:0] <= {devnum_q, 1'b0};
         end
         if (hit(wb_adr_i, `SLTS_IDX_COMMA)) begin
            dat_q[1:0] <= comma_sel_q;
         end
         if (hit(wb_adr_i, `SLTS_IDX_COND)) begin
            dat_q[`SLTS_BIT_UP] <= link_up;
            dat_q[`SLTS_BIT_SYNC] <= sync_n;
            dat_q[`SLTS_BIT_REALIGN] <= realign_q;
            dat_q[`SLTS_BIT_ALIGN] <= align_q;
            dat_q[`SLTS_BIT_LOCK] <= pll_locked;
         end
         if (hit(wb_adr_i, `SLTS_IDX_CTRL)) begin
            dat_q[`SLTS_BIT_EN] <= en_q;
            dat_q[`SLTS_BIT_8B10B] <= mode_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // comma code; reserved falls back to K28.7
   always_comb begin
      case (comma_sel_q)
         2'h1: comma_w = `SLTS_K28_1;
         2'h2: comma_w = `SLTS_K28_5;
         default: comma_w = `SLTS_K28_7;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // words move only when the buffer takes them; samples offered while
   // disabled or in a test mode are taken and dropped
   assign in_valid = en_q & ((test_q != slts_pkg::pat_off) | sample_valid);
   assign adv = in_valid & sample_ready;

   generate
      for (genvar g = 0; g < LANES; g++) begin : g_lane
         logic [7:0] did_w;
         // second link adds one to the even number
         assign did_w = (g >= LPL) ? {devnum_q, 1'b1} : {devnum_q, 1'b0};
         slts_lane_gen #(
            .LANE(g)
         ) u_gen (
            .clk(clk),
            .rst_n(rst_n),
            .advance(adv),
            .sel(test_q),
            .mode_8b10b(mode_q),
            .ila_device_number(did_w),
            .comma(comma_w),
            .sample(sample_data[g*16 +: 16]),
            .eof_ok(sample_eof_ok[g]),
            .word(word_w[g*16 +: 16]),
            .k(k_w[g*2 +: 2]),
            .raw(raw_w[g])
         );
      end
   endgenerate

   slts_skid #(
      .W(BW)
   ) u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_data({raw_w, k_w, word_w}),
      .in_valid(in_valid),
      .in_ready(sample_ready),
      .out_data(buf_out),
      .out_valid(lane_valid),
      .out_ready(lane_ready)
   );

   assign lane_data = buf_out[LANES*16-1:0];
   assign lane_k = buf_out[LANES*18-1:LANES*16];
   assign lane_raw = buf_out[BW-1:LANES*18];

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   generate
      for (genvar a = 0; a < LANES; a++) begin : g_chk
         a_normal_data: assert property (
            (test_q == slts_pkg::pat_off && !(mode_q && sample_eof_ok[a]))
            |-> (word_w[a*16 +: 16] == sample_data[a*16 +: 16]) && !raw_w[a])
            else $error("normal mode word differs from sample");
         a_prbs7_poly: assert property (
            (test_q == slts_pkg::pat_prbs7 && adv) ##1 (test_q == slts_pkg::pat_prbs7)
            |-> raw_w[a] && (word_w[a*16] == (word_w[a*16+7] ^ word_w[a*16+6])))
            else $error("prbs7 word breaks its polynomial");
         a_prbs15_poly: assert property (
            (test_q == slts_pkg::pat_prbs15 && adv) ##1 (test_q == slts_pkg::pat_prbs15)
            |-> word_w[a*16] == (word_w[a*16+15] ^ word_w[a*16+14]))
            else $error("prbs15 word breaks its polynomial");
         a_ramp_step: assert property (
            (test_q == slts_pkg::pat_ramp && adv) ##1 (test_q == slts_pkg::pat_ramp)
            |-> word_w[a*16 +: 8] == 8'($past(word_w[a*16 +: 8]) + 8'h02))
            else $error("ramp did not advance by two octets");
         a_k_needs_mode: assert property (
            (!mode_q && (test_q == slts_pkg::pat_k285 || test_q == slts_pkg::pat_k287
            || test_q == slts_pkg::pat_ila)) |-> k_w[a*2 +: 2] == 2'b00)
            else $error("control pattern sent outside 8b/10b mode");
         a_held_level: assert property (
            (test_q == slts_pkg::pat_low || test_q == slts_pkg::pat_high)
            |-> raw_w[a] && (word_w[a*16 +: 16] == {16{test_q[0]}}))
            else $error("held level wrong");
         a_clock_word: assert property (
            (test_q == slts_pkg::pat_clock) |-> word_w[a*16 +: 16] == `SLTS_CLK_WORD)
            else $error("clock pattern word wrong");
         a_comma_insert: assert property (
            (test_q == slts_pkg::pat_off && sample_eof_ok[a])
            |-> (mode_q == k_w[a*2]) && (!mode_q || word_w[a*16 +: 8] == comma_w))
            else $error("comma insertion wrong");
         a_link_number: assert property (
            (test_q == slts_pkg::pat_ila && k_w[a*2] && word_w[a*16 +: 8] == `SLTS_K28_4)
            |-> word_w[a*16+8 +: 8] == {devnum_q, 1'b0} + 8'(a >= LPL))
            else $error("device number of link wrong");
      end
   endgenerate

   a_devnum_even: assert property (
      (wr && hit(wb_adr_i, `SLTS_IDX_DEVNUM))
      |=> {devnum_q, 1'b0} == ($past(wb_dat_i[7:0]) & 8'hFE))
      else $error("device number not stored even");

   a_devnum_read: assert property (
      (rd && hit(wb_adr_i, `SLTS_IDX_DEVNUM)) |=> dat_q[0] == 1'b0)
      else $error("device number bit 0 not read as zero");

   a_comma_code: assert property (
      (comma_sel_q == 2'h1) |-> comma_w == `SLTS_K28_1)
      else $error("comma code for select one wrong");

   a_status_read: assert property (
      (rd && hit(wb_adr_i, `SLTS_IDX_COND))
      |=> ack_q && dat_q[6:5] == $past({link_up, sync_n}) && dat_q[2] == $past(pll_locked))
      else $error("status read does not mirror inputs");

   a_realign_set: assert property (
      realign_event |=> realign_q [*2] or (realign_q ##1 1'b1))
      else $error("realign flag not set by event");

   a_align_first: assert property (
      $rose(align_q) |-> $past(sysref_event && en_q && !sysref_seen_q))
      else $error("phase flag set without first sysref");

   a_ack_pulse: assert property (
      req |=> ack_q ##1 !ack_q)
      else $error("ack not a single cycle pulse");

endmodule: slts_regs

`default_nettype wire

/* File: slts_lane_sink.sv */
// slts_lane_sink.sv - lane word consumer model with stall control.
// assumes: a word is taken at each edge where valid and ready are high.
`timescale 1ns/1ps
`default_nettype none

module slts_lane_sink (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // lane stream
   input wire logic [127:0] lane_data,
   input wire logic [7:0] lane_raw,
   input wire logic lane_valid,
   output logic lane_ready,
   // control and record
   input wire logic stall,
   output logic [3:0] cnt_q,
   output logic [15:0] last0_q,
   output logic [15:0] last7_q,
   output logic raw0_q
);
   ////////////////////////////////////////
   logic [15:0] hist_q [0:15];

   // ready follows stall one edge late, like a registered consumer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lane_ready <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         lane_ready <= !stall;
         if (lane_valid && lane_ready) begin
            hist_q[cnt_q] <= lane_data[15:0];
            cnt_q <= cnt_q + 4'h1;
            last0_q <= lane_data[15:0];
            last7_q <= lane_data[127:112];
            raw0_q <= lane_raw[0];
         end
      end
   end
endmodule: slts_lane_sink

`default_nettype wire

/* File: tb.sv */
// tb.sv - self-checking bench of the serial link test and status block.
// assumes: slts_regs with LPL=4 and the lane sink model beside it.
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic clk, rst_n, cyc, stb, we, lup, syn, pll, sref, realn, svalid, sready;
   logic ack, en, m8, lvalid, lready, stall, raw0;
   logic [11:0] adr;
   logic [3:0] sel, cnt;
   logic [31:0] dat, dato, rd;
   logic [127:0] sdata, ldata;
   logic [15:0] lk, last0, last7;
   logic [7:0] lraw, eof;
   int fails, tests_run, cycles;

   slts_regs slts_regs_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
      .wb_ack_o(ack), .link_up(lup), .sync_n(syn), .pll_locked(pll),
      .sysref_event(sref), .realign_event(realn), .link_transmit_enable(en),
      .link_mode_8b10b(m8), .sample_data(sdata), .sample_eof_ok(eof),
      .sample_valid(svalid), .sample_ready(sready), .lane_data(ldata), .lane_k(lk),
      .lane_raw(lraw), .lane_valid(lvalid), .lane_ready(lready));

   slts_lane_sink slts_lane_sink_inst (.clk(clk), .rst_n(rst_n), .lane_data(ldata),
      .lane_raw(lraw), .lane_valid(lvalid), .lane_ready(lready), .stall(stall),
      .cnt_q(cnt), .last0_q(last0), .last7_q(last7), .raw0_q(raw0));

   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask: chk

   // classic cycle: held until ack is sampled high, released at that edge
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         fails++;
         final_report();
      end
   endtask: wb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask: rdchk

   task automatic push(input logic [15:0] b);
      int n;
      logic [127:0] d;
      for (int g = 0; g < 8; g++) d[g*16+:16] = b + 16'(g);
      n = 0;
      @(posedge clk);
      sdata <= d;
      svalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (sready !== 1'b1 && n < 50);
      svalid <= 1'b0;
      if (n >= 50) begin
         fails++;
         final_report();
      end
   endtask: push

   ////////////////////////////////////////
   task automatic t_fields;
      rdchk(12'h814, 32'h0);
      rdchk(12'h818, 32'h0);
      rdchk(12'h81C, 32'h0);
      rdchk(12'h820, 32'h0);
      wb(1'b1, 12'h814, 32'hFF);
      rdchk(12'h814, 32'h1F);
      wb(1'b1, 12'h818, 32'h07);
      rdchk(12'h818, 32'h06);
      wb(1'b1, 12'h818, 32'hFF);
      rdchk(12'h818, 32'hFE);
      wb(1'b1, 12'h81C, 32'hFF);
      rdchk(12'h81C, 32'h03);
      wb(1'b1, 12'h900, 32'hFF);
      rdchk(12'h900, 32'h0);
      wb(1'b1, 12'h814, 32'h0);
      $display("field test done");
   endtask: t_fields

   task automatic t_status;
      lup <= 1'b1;
      syn <= 1'b1;
      pll <= 1'b1;
      rdchk(12'h820, 32'h64);
      syn <= 1'b0;
      rdchk(12'h820, 32'h44);
      syn <= 1'b1;
      @(posedge clk);
      realn <= 1'b1;
      @(posedge clk);
      realn <= 1'b0;
      rdchk(12'h820, 32'h74);
      wb(1'b1, 12'h820, 32'h10);
      rdchk(12'h820, 32'h64);
      wb(1'b1, 12'h840, 32'h1);
      // only the first event after enable sets the flag; disabling rearms it
      for (int i = 0; i < 3; i++) begin
         if (i == 2) begin
            wb(1'b1, 12'h840, 32'h0);
            wb(1'b1, 12'h840, 32'h1);
         end
         @(posedge clk);
         sref <= 1'b1;
         @(posedge clk);
         sref <= 1'b0;
         rdchk(12'h820, (i == 1) ? 32'h64 : 32'h6C);
         wb(1'b1, 12'h820, 32'h08);
      end
      rdchk(12'h820, 32'h64);
      wb(1'b1, 12'h840, 32'h0);
      $display("status test done");
   endtask: t_status

   task automatic t_stream;
      logic [3:0] b;
      wb(1'b1, 12'h840, 32'h1);
      push(16'hA000);
      repeat (4) @(posedge clk);
      chk(last0, 32'hA000);
      chk(last7, 32'hA007);
      stall <= 1'b1;
      repeat (2) @(posedge clk);
      b = cnt;
      push(16'hB000);
      push(16'hC000);
      repeat (2) @(posedge clk);
      chk(sready, 1'b0);
      stall <= 1'b0;
      push(16'hD000);
      repeat (6) @(posedge clk);
      chk(slts_lane_sink_inst.hist_q[b], 32'hB000);
      chk(slts_lane_sink_inst.hist_q[b+4'h1], 32'hC000);
      chk(slts_lane_sink_inst.hist_q[b+4'h2], 32'hD000);
      $display("stream test done");
   endtask: t_stream

   task automatic t_patterns;
      logic [4:0] code [0:2];
      logic [15:0] exp [0:2];
      code = '{5'h0A, 5'h0B, 5'h0F};
      exp = '{16'h0000, 16'hFFFF, 16'h00FF};
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, 12'h840, 32'h0);
         wb(1'b1, 12'h814, {27'h0, code[i]});
         wb(1'b1, 12'h840, 32'h1);
         repeat (6) @(posedge clk);
         chk(last0, exp[i]);
         chk(last7, exp[i]);
         chk(raw0, 1'b1);
      end
      // prbs7, prbs15 and ramp: relations inside one word
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, 12'h840, 32'h0);
         wb(1'b1, 12'h814, (i == 2) ? 32'h4 : 32'(i + 1));
         wb(1'b1, 12'h840, 32'h1);
         repeat (6) @(posedge clk);
         chk(raw0, i != 2);
         if (i == 0) chk(last0[0], last0[7] ^ last0[6]);
         if (i == 1) chk(last0[0], last0[15] ^ last0[14]);
         if (i == 2) chk(last0[15:8], 8'(last0[7:0] + 8'h01));
      end
      wb(1'b1, 12'h840, 32'h0);
      $display("pattern test done");
   endtask: t_patterns

   task automatic t_comma;
      logic [31:0] e;
      eof <= 8'h01;
      for (int i = 1; i < 4; i++) begin
         // set while disabled; comma one or two
         wb(1'b1, 12'h840, 32'h0);
         wb(1'b1, 12'h81C, (i == 1) ? 32'h1 : 32'h2);
         wb(1'b1, 12'h840, (i == 3) ? 32'h1 : 32'h3);
         e = (i == 1) ? 32'h1503C : (i == 2) ? 32'h150BC : 32'h5000;
         stall <= 1'b1;
         repeat (2) @(posedge clk);
         push(16'h5000);
         @(posedge clk);
         chk({en, m8, ldata[127:112]}, (i == 3) ? 32'h25007 : 32'h35007);
         chk({lk[1:0], ldata[15:0]}, e);
         stall <= 1'b0;
         repeat (4) @(posedge clk);
      end
      eof <= 8'h00;
      $display("comma test done");
   endtask: t_comma

   task automatic t_ila;
      int hits;
      hits = 0;
      wb(1'b1, 12'h814, 32'h8);
      wb(1'b1, 12'h840, 32'h3);
      repeat (24) @(posedge clk);
      wb(1'b1, 12'h840, 32'h2);
      repeat (4) @(posedge clk);
      for (int j = 0; j < 16; j++) begin
         if (slts_lane_sink_inst.hist_q[j][7:0] == 8'h9C) begin
            hits++;
            chk(slts_lane_sink_inst.hist_q[j][15:8], 32'hFE);
         end
      end
      chk(hits, 32'h1);
      wb(1'b1, 12'h840, 32'h1);
      repeat (6) @(posedge clk);
      chk(last0, 32'h0);
      wb(1'b1, 12'h840, 32'h0);
      $display("alignment test done");
   endtask: t_ila

   task final_report;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask: final_report

   // a hang is cut short well past the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         final_report();
      end
   end

   initial begin
      {rst_n, cyc, stb, we, lup, syn, pll, sref, realn, svalid, stall} = '0;
      adr = 12'h0;
      sel = 4'h0;
      dat = 32'h0;
      sdata = '0;
      eof = 8'h00;
      fails = 0;
      tests_run = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_fields();
      t_status();
      t_stream();
      t_comma();
      t_patterns();
      t_ila();
      final_report();
   end
endmodule: tb

`default_nettype wire
